// ### core/scl_regs.svh
// Constants for the strap configuration latch
// Overview of operation
// - Sample three low management address straps at reset; any address 0 to 7.
// - A pulled-up address strap latches as one, pulled-down as zero.
// - Upper two bits of the five-bit management address are always zero.
// - Latch four-bit mode; 0001 MAC interface, 0100 NAND tree, 0111 power-down.
// - Latched clock enable strap high enables the 125MHz reference clock output while the software clock mask bit is clear.
// - Latched lamp strap high selects single lamp, low selects tri-colour dual lamp.
// - All straps are captured two clocks after the rising edge of the active-low chip reset leaves its two-flop synchronizer.
// - Shared pins act as strap inputs only during reset, then drive normally.
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
`define SCL_ADDR_W 12
`define SCL_OFF_CFG 12'h000
`define SCL_OFF_CTRL 12'h004
`define SCL_CFG_ADDR_LSB 0
`define SCL_CFG_MODE_LSB 8
`define SCL_CFG_CLKEN_BIT 12
`define SCL_CFG_LAMP_BIT 13
`define SCL_CFG_MACIF_BIT 16
`define SCL_CFG_NAND_BIT 17
`define SCL_CFG_PDOWN_BIT 18
`define SCL_CFG_RSVD_BIT 19
`define SCL_CFG_DONE_BIT 24
`define SCL_CTRL_CLKMASK_BIT 0
`define SCL_MODE_MACIF 4'h1
`define SCL_MODE_NAND 4'h4
`define SCL_MODE_PDOWN 4'h7
`define SCL_RST_ADDR 3'h0
`define SCL_RST_MODE 4'h1
`define SCL_RST_CLKEN 1'b0
`define SCL_RST_LAMP 1'b0
`define SCL_RST_CLKMASK 1'b0
`define SCL_ADDR_HI 2'h0
`define SCL_NPINS 9
`endif

// ### core/scl_pkg.sv
// Types for the strap configuration latch
package scl_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN = 3'b100
  } scl_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scl_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scl_apb_rsp_s;

  typedef struct packed {
    logic [2:0] mgmt_address_strap;
    logic [3:0] mode_strap;
    logic ref_clock_out_enable_strap;
    logic lamp_style_strap;
  } scl_straps_s;

  typedef struct packed {
    logic [4:0] mgmt_addr;
    logic [3:0] mode;
    logic mode_mac_if;
    logic mode_nand_tree;
    logic mode_power_down;
    logic mode_reserved;
    logic ref_clock_out_enable;
    logic lamp_single;
  } scl_cfg_s;
endpackage

// ### core/scl_strap_latch.sv
// Strap configuration latch with APB status and control
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scl_regs.svh"
module scl_strap_latch (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic chip_reset_n_in,
  input wire scl_pkg::scl_straps_s strap_pins_in,
  input wire logic [`SCL_NPINS-1:0] rx_drive_in,
  output logic [`SCL_NPINS-1:0] pin_out,
  output logic [`SCL_NPINS-1:0] pin_oe_out,
  output scl_pkg::scl_cfg_s cfg_out,
  output logic ref_clk_out_en_out,
  output logic config_done_out,
  input wire scl_pkg::scl_apb_req_s apb_req_in,
  output scl_pkg::scl_apb_rsp_s apb_rsp_out
);
  import scl_pkg::*;

  logic rstn_s1_r;
  logic rstn_s2_r;
  scl_straps_s strap_s1_r;
  scl_straps_s strap_s2_r;
  scl_state_e st_r;
  scl_cfg_s cfg_r;
  logic clk_mask_r;
  logic [`SCL_NPINS-1:0] pin_out_r;
  logic [`SCL_NPINS-1:0] pin_oe_r;
  logic [31:0] rd_word;
  logic rd_hit;

  function automatic logic [3:0] decode_mode(input logic [3:0] m);
    decode_mode = {m == `SCL_MODE_MACIF, m == `SCL_MODE_NAND, m == `SCL_MODE_PDOWN,
                   !(m == `SCL_MODE_MACIF || m == `SCL_MODE_NAND || m == `SCL_MODE_PDOWN)};
  endfunction

  // Reset pin comes from the board
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rstn_s1_r <= 1'b0;
      rstn_s2_r <= 1'b0;
    end else begin
      rstn_s1_r <= chip_reset_n_in;
      rstn_s2_r <= rstn_s1_r;
    end
  end

  // Strap levels come from the board too
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1_r <= '0;
      strap_s2_r <= '0;
    end else begin
      strap_s1_r <= strap_pins_in;
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= ST_RESET;
    end else if (!rstn_s2_r) begin
      st_r <= ST_RESET;
    end else begin
      case (st_r)
        ST_RESET: st_r <= ST_CAPTURE;
        ST_CAPTURE: st_r <= ST_RUN;
        ST_RUN: st_r <= ST_RUN;
        default: st_r <= ST_RESET;
      endcase
    end
  end

  // Capture once, on the cycle after reset release is seen
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r.mgmt_addr <= {`SCL_ADDR_HI, `SCL_RST_ADDR};
      cfg_r.mode <= `SCL_RST_MODE;
      {cfg_r.mode_mac_if, cfg_r.mode_nand_tree, cfg_r.mode_power_down,
       cfg_r.mode_reserved} <= 4'h8;
      cfg_r.ref_clock_out_enable <= `SCL_RST_CLKEN;
      cfg_r.lamp_single <= `SCL_RST_LAMP;
    end else if (st_r == ST_CAPTURE) begin
      cfg_r.mgmt_addr <= {`SCL_ADDR_HI, strap_s2_r.mgmt_address_strap};
      cfg_r.mode <= strap_s2_r.mode_strap;
      {cfg_r.mode_mac_if, cfg_r.mode_nand_tree, cfg_r.mode_power_down,
       cfg_r.mode_reserved} <= decode_mode(strap_s2_r.mode_strap);
      cfg_r.ref_clock_out_enable <= strap_s2_r.ref_clock_out_enable_strap;
      cfg_r.lamp_single <= strap_s2_r.lamp_style_strap;
    end
  end

  // Normal output values for the shared pins
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out_r <= '0;
    end else begin
      pin_out_r <= rx_drive_in;
    end
  end

  // Shared pins stay undriven until straps are taken
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_oe_r <= '0;
    end else begin
      pin_oe_r <= {`SCL_NPINS{st_r == ST_RUN && rstn_s2_r}};
    end
  end

  // Software mask of the reference clock output
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_mask_r <= `SCL_RST_CLKMASK;
    end else if (apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite &&
                 apb_req_in.paddr == `SCL_OFF_CTRL) begin
      clk_mask_r <= apb_req_in.pwdata[`SCL_CTRL_CLKMASK_BIT];
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (apb_req_in.paddr)
      `SCL_OFF_CFG: begin
        rd_word[`SCL_CFG_ADDR_LSB +: 5] = cfg_r.mgmt_addr;
        rd_word[`SCL_CFG_MODE_LSB +: 4] = cfg_r.mode;
        rd_word[`SCL_CFG_CLKEN_BIT] = cfg_r.ref_clock_out_enable;
        rd_word[`SCL_CFG_LAMP_BIT] = cfg_r.lamp_single;
        rd_word[`SCL_CFG_MACIF_BIT] = cfg_r.mode_mac_if;
        rd_word[`SCL_CFG_NAND_BIT] = cfg_r.mode_nand_tree;
        rd_word[`SCL_CFG_PDOWN_BIT] = cfg_r.mode_power_down;
        rd_word[`SCL_CFG_RSVD_BIT] = cfg_r.mode_reserved;
        rd_word[`SCL_CFG_DONE_BIT] = (st_r == ST_RUN);
      end
      `SCL_OFF_CTRL: begin
        rd_word[`SCL_CTRL_CLKMASK_BIT] = clk_mask_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign apb_rsp_out.pready = 1'b1;
  assign apb_rsp_out.pslverr = apb_req_in.psel && apb_req_in.penable && !rd_hit;
  assign apb_rsp_out.prdata = (apb_req_in.psel && apb_req_in.penable && !apb_req_in.pwrite)
                              ? rd_word : 32'h0000_0000;
  assign cfg_out = cfg_r;
  assign pin_out = pin_out_r;
  assign pin_oe_out = pin_oe_r;
  assign ref_clk_out_en_out = cfg_r.ref_clock_out_enable && !clk_mask_r;
  assign config_done_out = (st_r == ST_RUN);

  a_addr_upper_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cfg_r.mgmt_addr[4:3] == 2'h0) else $error("Upper address bits not zero");
  a_addr_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE |=> cfg_r.mgmt_addr[2:0] == $past(strap_s2_r.mgmt_address_strap))
    else $error("Address strap not latched");
  a_capture_order: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(rstn_s2_r) |-> st_r == ST_RESET ##1 st_r == ST_CAPTURE ##1 st_r == ST_RUN)
    else $error("Capture not at reset release");
  a_mode_decode: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_RUN |-> (cfg_r.mode_nand_tree == (cfg_r.mode == 4'h4)) &&
      (cfg_r.mode_power_down == (cfg_r.mode == 4'h7)) &&
      (cfg_r.mode_mac_if == (cfg_r.mode == 4'h1))) else $error("Mode decode wrong");
  a_clk_out_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE && strap_s2_r.ref_clock_out_enable_strap
    |=> ref_clk_out_en_out == !clk_mask_r) else $error("Clock output not enabled");
  a_lamp_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE |=> cfg_r.lamp_single == $past(strap_s2_r.lamp_style_strap))
    else $error("Lamp strap not latched");
  a_pins_released: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rstn_s2_r |=> pin_oe_r == '0) else $error("Shared pins driven during reset");
  a_cfg_stable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_RUN && $past(st_r) == ST_RUN |-> $stable(cfg_r))
    else $error("Latched config changed in run");

  // Further capture checks
  a_mode_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE |=> cfg_r.mode == $past(strap_s2_r.mode_strap))
    else $error("Mode strap not latched");
  a_mode_reserved: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_RUN |-> cfg_r.mode_reserved ==
      !(cfg_r.mode inside {`SCL_MODE_MACIF, `SCL_MODE_NAND, `SCL_MODE_PDOWN}))
    else $error("Reserved mode flag wrong");
  a_mode_onehot: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $onehot({cfg_r.mode_mac_if, cfg_r.mode_nand_tree, cfg_r.mode_power_down,
      cfg_r.mode_reserved})) else $error("Mode flags not one-hot");
  a_clken_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE |=> cfg_r.ref_clock_out_enable ==
      $past(strap_s2_r.ref_clock_out_enable_strap))
    else $error("Clock enable strap not latched");
  a_reset_holds: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rstn_s2_r |=> st_r == ST_RESET)
    else $error("State left reset while pin low");
  a_done_follows: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE && rstn_s2_r |=> config_done_out)
    else $error("Run state not entered after capture");
  a_capture_only: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r != ST_CAPTURE |=> $stable(cfg_r))
    else $error("Config changed outside capture");

  // Shared pin and control checks
  a_pins_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_CAPTURE |-> pin_oe_r == '0)
    else $error("Shared pins driven while straps taken");
  a_pins_driven: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    st_r == ST_RUN && rstn_s2_r |=> pin_oe_r == '1)
    else $error("Shared pins not driven in run");
  a_pins_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rstn_s2_r |=> pin_out_r == $past(rx_drive_in))
    else $error("Shared pin value not forwarded");
  a_mask_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite &&
    apb_req_in.paddr == `SCL_OFF_CTRL |=>
      clk_mask_r == $past(apb_req_in.pwdata[`SCL_CTRL_CLKMASK_BIT]))
    else $error("Clock mask write lost");
endmodule // scl_strap_latch
`default_nettype wire

// ### bench/scl_board.sv
// Board strap resistors and active-low chip reset
`timescale 1ns/1ps
`default_nettype none
module scl_board (
  input wire logic ref_clk_in,
  input wire logic [8:0] level_in,
  input wire logic release_in,
  output scl_pkg::scl_straps_s strap_out,
  output logic chip_reset_n_out
);
  import scl_pkg::*;
  // Strap levels and reset release pass through one register on each clock
  always_ff @(posedge ref_clk_in) begin
    strap_out <= level_in;
    chip_reset_n_out <= release_in;
  end
endmodule // scl_board
`default_nettype wire

// ### bench/strap_config_latch_bench.sv
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ps
`default_nettype none
module strap_config_latch_bench;
  import scl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rel = 1'b0;
  logic [8:0] lvl = 9'h000;
  logic [8:0] rx = 9'h000;
  scl_apb_req_s req = '0;
  scl_apb_rsp_s rsp;
  scl_straps_s straps;
  scl_cfg_s cfg;
  wire logic chip_n;
  logic [8:0] pin_out, pin_oe;
  logic en, done;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int total_checks = 0;
  logic [8:0] lv [5] = '{9'h1C7, 9'h010, 9'h15E, 9'h081, 9'h0FE};
  scl_board board (.ref_clk_in(clk), .level_in(lvl), .release_in(rel),
    .strap_out(straps), .chip_reset_n_out(chip_n));
  scl_strap_latch dut (.ref_clk_in(clk), .rst_in(rst), .chip_reset_n_in(chip_n),
    .strap_pins_in(straps), .rx_drive_in(rx), .pin_out(pin_out), .pin_oe_out(pin_oe),
    .cfg_out(cfg), .ref_clk_out_en_out(en), .config_done_out(done),
    .apb_req_in(req), .apb_rsp_out(rsp));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [14:0] ecfg(input logic [8:0] l);
    logic [3:0] m;
    m = l[5:2];
    return {2'b00, l[8:6], m, m == 4'h1, m == 4'h4, m == 4'h7,
      !(m == 4'h1 || m == 4'h4 || m == 4'h7), l[1], l[0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic capture(input logic [8:0] l);
    int n;
    logic [14:0] c;
    logic [31:0] x;
    c = ecfg(l);
    rel <= 1'b0;
    lvl <= l;
    repeat (6) @(posedge clk);
    chk(pin_oe, 32'h0000_0000);
    rel <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    repeat (2) @(posedge clk);
    chk(done, 32'h0000_0001);
    chk(cfg, c);
    chk(en, l[1]);
    chk(pin_oe, 32'h0000_01FF);
    x = {8'h01, 4'h0, c[2], c[3], c[4], c[5], 2'h0, c[0], c[1], c[9:6], 3'h0, c[14:10]};
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(q, x);
  endtask
  task automatic t_hold;
    lvl <= ~lvl;
    rx <= 9'h0A5;
    repeat (6) @(posedge clk);
    chk(cfg, ecfg(9'h0FE));
    chk(pin_out, 32'h0000_00A5);
    $display("hold test done");
  endtask
  task automatic t_mask;
    apb(1'b1, 12'h004, 32'h0000_0001);
    @(posedge clk);
    chk(en, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    @(posedge clk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    @(posedge clk);
    apb(1'b1, 12'h004, 32'h0000_0000);
    @(posedge clk);
    chk(en, 32'h0000_0001);
    $display("mask test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (lv[i]) capture(lv[i]);
    $display("strap test done");
    t_hold();
    t_mask();
    end_of_test();
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
endmodule // strap_config_latch_bench
`default_nettype wire
